// file: core/nid_pkg.sv
// Function
// - power-up recall runs its full time; memory refused, busy pin driven meanwhile
// - after power-up: single lane, busy pin pulled up, lanes released
// - power-up clears write latch; lock and protect bits keep stored values
// - write-protect and lane-3 pull-ups on while four-lane enable is clear
// - supply below threshold: every instruction is ignored
// - final write bit seen at power loss: inhibit at once, grace time, then save
// - active while select low; standby waits for store or recall to end
// - opcode held in 8-bit register; every frame opens with select falling
// - 04h clears and 06h sets the write latch, all protocols
// - lane protocol switches 37h, 38h, FFh allowed only from the listed protocols
// - plain read, fast read and write decoded in all protocols
// - dual and quad read variants decoded in single lane only
// - dual and quad write variants decoded in single lane only
// - software reset fires only when 99h directly follows 66h
// - clock read, write and fast read decoded in all protocols
// - deep power-down, sleep and wake decoded in all protocols
// - status read and write decoded in all protocols
// - config read in all protocols; config write refused in four lane
// - serial id write, read and fast read decoded in all protocols
// - store, recall, auto-save on and off decoded in all protocols
// - reserved opcodes corrupt setup until the software reset
// - invalid opcode: ignore rest of frame, outputs stay released
// - three address bytes msb first; only the low 17 bits kept
// - clock level at select picks mode 0 or 3; sample on rising edge
`default_nettype none
package nid_pkg;
	localparam int CLK_MHZ = 125;
	localparam int NS_PER_US = 1000;
	localparam int CMD_W = 29;
	localparam int ADDR_USED = 17;
	localparam logic [4:0] OPC_BITS = 5'h08;
	localparam logic [4:0] ADDR_BITS = 5'h18;
	localparam logic [2:0] LANES_1 = 3'h1;
	localparam logic [2:0] LANES_2 = 3'h2;
	localparam logic [2:0] LANES_4 = 3'h4;
	localparam logic [6:0] SYNC_RST = 7'h41; // select high, supply good: no false loss after reset
	localparam logic WEL_RST = 1'b0;
	localparam logic AUTO_SAVE_RST = 1'b1;

	typedef enum logic [1:0] {PROTO_SINGLE, PROTO_TWO, PROTO_FOUR} nid_proto_t;
	typedef enum logic [3:0] {CLS_BAD, CLS_RSVD, CLS_WEL, CLS_PROTO, CLS_MEMRD, CLS_MEMWR,
		CLS_RESET, CLS_RTC, CLS_PWR, CLS_REG, CLS_SN, CLS_NV} nid_cls_t;
	typedef enum logic [2:0] {FR_IDLE, FR_OPC, FR_ADDR, FR_DONE, FR_IGNORE} nid_frame_t;
	typedef enum logic [2:0] {PW_RECALL, PW_ON, PW_GRACE, PW_SAVE, PW_OFF} nid_power_t;

	localparam logic [7:0] OP_WL_CLR = 8'h04, OP_WL_SET = 8'h06;
	localparam logic [7:0] OP_TWO_EN = 8'h37, OP_FOUR_EN = 8'h38, OP_ONE_EN = 8'hff;
	localparam logic [7:0] OP_RD = 8'h03, OP_FRD = 8'h0b, OP_WR = 8'h02;
	localparam logic [7:0] OP_DUAL_OUT_RD = 8'h3b, OP_FOUR_OUT_RD = 8'h6b;
	localparam logic [7:0] OP_TWO_ADDR_RD = 8'hbb, OP_FOUR_ADDR_RD = 8'heb;
	localparam logic [7:0] OP_TWO_DATA_WR = 8'ha2, OP_FOUR_DATA_WR = 8'h32;
	localparam logic [7:0] OP_TWO_ADDR_WR = 8'ha1, OP_FOUR_ADDR_WR = 8'hd2;
	localparam logic [7:0] OP_RST_ARM = 8'h66, OP_RST = 8'h99;
	localparam logic [7:0] OP_CLK_RD = 8'h56, OP_CLK_WR = 8'h55, OP_CLK_FRD = 8'h57;
	localparam logic [7:0] OP_DEEP_PD = 8'hba, OP_SLEEP = 8'hb9, OP_WAKE = 8'hab;
	localparam logic [7:0] OP_STAT_RD = 8'h05, OP_STAT_WR = 8'h01;
	localparam logic [7:0] OP_CFG_RD = 8'h35, OP_CFG_WR = 8'h87;
	localparam logic [7:0] OP_SID_WR = 8'hc2, OP_SID_RD = 8'hc3, OP_SID_FRD = 8'hc9;
	localparam logic [7:0] OP_NV_SAVE = 8'h8c, OP_NV_LOAD = 8'h8d;
	localparam logic [7:0] OP_AUTO_ON = 8'h8e, OP_AUTO_OFF = 8'h8f;
	localparam logic [7:0] OP_RSV0 = 8'hc5, OP_RSV1 = 8'h1e, OP_RSV2 = 8'hc8, OP_RSV3 = 8'hce;
	localparam logic [7:0] OP_RSV4 = 8'hcb, OP_RSV5 = 8'hcc, OP_RSV6 = 8'hcd;

	// least time in ns to whole cycles, never below one
	function automatic int nid_cycles(input int ns);
		int c;
		c = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
		return (c < 1) ? 1 : c;
	endfunction : nid_cycles

	function automatic nid_cls_t nid_decode(input logic [7:0] op, input nid_proto_t pr);
		logic one;
		one = (pr == PROTO_SINGLE);
		case (op)
			OP_WL_CLR, OP_WL_SET: return CLS_WEL;
			OP_TWO_EN: return (pr != PROTO_TWO) ? CLS_PROTO : CLS_BAD;
			OP_FOUR_EN: return (pr != PROTO_FOUR) ? CLS_PROTO : CLS_BAD;
			OP_ONE_EN: return one ? CLS_BAD : CLS_PROTO;
			OP_RD, OP_FRD: return CLS_MEMRD;
			OP_WR: return CLS_MEMWR;
			OP_DUAL_OUT_RD, OP_FOUR_OUT_RD, OP_TWO_ADDR_RD, OP_FOUR_ADDR_RD:
				return one ? CLS_MEMRD : CLS_BAD;
			OP_TWO_DATA_WR, OP_FOUR_DATA_WR, OP_TWO_ADDR_WR, OP_FOUR_ADDR_WR:
				return one ? CLS_MEMWR : CLS_BAD;
			OP_RST_ARM, OP_RST: return CLS_RESET;
			OP_CLK_RD, OP_CLK_WR, OP_CLK_FRD: return CLS_RTC;
			OP_DEEP_PD, OP_SLEEP, OP_WAKE: return CLS_PWR;
			OP_STAT_RD, OP_STAT_WR, OP_CFG_RD: return CLS_REG;
			OP_CFG_WR: return (pr != PROTO_FOUR) ? CLS_REG : CLS_BAD;
			OP_SID_WR, OP_SID_RD, OP_SID_FRD: return CLS_SN;
			OP_NV_SAVE, OP_NV_LOAD, OP_AUTO_ON, OP_AUTO_OFF: return CLS_NV;
			OP_RSV0, OP_RSV1, OP_RSV2, OP_RSV3, OP_RSV4, OP_RSV5, OP_RSV6:
				return CLS_RSVD;
			default: return CLS_BAD;
		endcase
	endfunction : nid_decode

	// lanes carrying the address bytes
	function automatic logic [2:0] nid_addr_lanes(input logic [7:0] op, input nid_proto_t pr);
		if (op == OP_FOUR_ADDR_RD || op == OP_FOUR_ADDR_WR || pr == PROTO_FOUR)
			return LANES_4;
		if (op == OP_TWO_ADDR_RD || op == OP_TWO_ADDR_WR || pr == PROTO_TWO)
			return LANES_2;
		return LANES_1;
	endfunction : nid_addr_lanes
endpackage : nid_pkg
`default_nettype wire

// file: core/nid_cmd_buf.sv
`timescale 1ns/10ps
`default_nettype none
module nid_cmd_buf #(
	parameter int WIDTH = 29,
	parameter int DEPTH = 2
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	localparam logic [AW:0] ONE = (AW + 1)'(1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign inReady = (count != FULL);
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_ff @(posedge mclk) begin
		if (push)
			mem[wrPtr] <= inData;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push)
				wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + 1'b1;
			if (pop)
				rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + 1'b1;
			if (push && !pop)
				count <= count + ONE;
			else if (pop && !push)
				count <= count - ONE;
		end
	end

	// a stalled word must not move or change
	property p_hold;
		@(posedge mclk) disable iff (rst)
		outValid && !outReady |=> outValid && $stable(outData);
	endproperty
	a_hold: assert property (p_hold) else $error("buffer head changed while stalled");
endmodule : nid_cmd_buf
`default_nettype wire

// file: core/nid_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module nid_decoder #(
	parameter int RECALL_NS = 20000,
	parameter int GRACE_NS = 1000
) (
	input  wire logic           mclk,
	input  wire logic           rst,
	input  wire logic           csN,
	input  wire logic           sck,
	input  wire logic [3:0]     ioIn,
	output logic [3:0]          ioOut,
	output logic [3:0]          ioOeN,
	input  wire logic           pwrOk,
	input  wire logic           quadEnable,
	input  wire logic           arrayBusy,
	input  wire logic           writeLastBit,
	input  wire logic           nvStatusLock,
	input  wire logic           nvIdLock,
	input  wire logic [2:0]     nvBlockProtect,
	output logic                hwStoreBusyOut,
	output logic                hwStoreBusyOeN,
	output logic                hwStorePullupEn,
	output logic                wpPullupEn,
	output logic                lane3PullupEn,
	output logic                writeEnableLatch,
	output logic                statusLockBit,
	output logic                serialIdLockBit,
	output logic [2:0]          blockProtectBits,
	output var nid_pkg::nid_proto_t laneProtocol,
	output logic                spiMode3,
	output logic                activeMode,
	output logic                standbyMode,
	output logic                memInhibit,
	output logic                autoSaveReq,
	output logic                autoSaveEnabled,
	output logic                swResetPulse,
	output logic                reservedTaint,
	output logic                cmdValid,
	input  wire logic           cmdReady,
	output logic [3:0]          cmdClass,
	output logic [7:0]          cmdOpcode,
	output logic [16:0]         cmdAddr,
	output logic                cmdOverrun
);
	localparam int RECALL_CYC = nid_pkg::nid_cycles(RECALL_NS);
	localparam int GRACE_CYC = nid_pkg::nid_cycles(GRACE_NS);
	localparam int TMAX = (RECALL_CYC > GRACE_CYC) ? RECALL_CYC : GRACE_CYC;
	localparam int TW = $clog2(TMAX + 1);
	localparam logic [TW-1:0] RECALL_LAST = TW'(RECALL_CYC - 1);
	localparam logic [TW-1:0] GRACE_LAST = TW'(GRACE_CYC - 1);

	//--------------------------------------------------
	// pin synchronisers
	//--------------------------------------------------
	logic [6:0] syncMeta;
	logic [6:0] syncOut;
	logic       csS;
	logic       sckS;
	logic [3:0] ioS;
	logic       pwrOkS;
	logic       sckPrev;

	always_ff @(posedge mclk) begin
		if (rst) begin
			syncMeta <= nid_pkg::SYNC_RST;
			syncOut <= nid_pkg::SYNC_RST;
		end else begin
			syncMeta <= {csN, sck, ioIn, pwrOk};
			syncOut <= syncMeta;
		end
	end

	assign {csS, sckS, ioS, pwrOkS} = syncOut;

	always_ff @(posedge mclk) begin
		if (rst)
			sckPrev <= 1'b0;
		else
			sckPrev <= sckS;
	end

	//--------------------------------------------------
	// frame decode
	//--------------------------------------------------
	nid_pkg::nid_frame_t frState;
	nid_pkg::nid_power_t pwrState;
	nid_pkg::nid_proto_t proto;
	nid_pkg::nid_cls_t   rawCls;
	nid_pkg::nid_cls_t   decCls;
	nid_pkg::nid_cls_t   frCls;
	logic [23:0]         sreg;
	logic [23:0]         shiftNext;
	logic [4:0]          bitCnt;
	logic [4:0]          nextCnt;
	logic [2:0]          lanes;
	logic [2:0]          protoLanes;
	logic [2:0]          addrLanes;
	logic [7:0]          opcode;
	logic [7:0]          curOp;
	logic                sckRise;
	logic                pwrLive;
	logic                recalling;
	logic                decValid;
	logic                addrDone;
	logic                isMem;
	logic                swFire;
	logic                armed;
	logic                dirty;
	logic [TW-1:0]       timer;

	assign sckRise = sckS && !sckPrev && !csS;
	assign pwrLive = (pwrState == nid_pkg::PW_ON) || (pwrState == nid_pkg::PW_RECALL);
	assign recalling = (pwrState == nid_pkg::PW_RECALL);
	assign protoLanes = (proto == nid_pkg::PROTO_FOUR) ? nid_pkg::LANES_4 :
		(proto == nid_pkg::PROTO_TWO) ? nid_pkg::LANES_2 : nid_pkg::LANES_1;
	assign lanes = (frState == nid_pkg::FR_ADDR) ? addrLanes : protoLanes;
	assign nextCnt = bitCnt + {2'h0, lanes};

	always_comb begin
		case (lanes)
			nid_pkg::LANES_4: shiftNext = {sreg[19:0], ioS};
			nid_pkg::LANES_2: shiftNext = {sreg[21:0], ioS[1:0]};
			default: shiftNext = {sreg[22:0], ioS[0]};
		endcase
	end

	assign curOp = shiftNext[7:0];
	assign rawCls = nid_pkg::nid_decode(curOp, proto);
	assign isMem = (rawCls == nid_pkg::CLS_MEMRD) || (rawCls == nid_pkg::CLS_MEMWR);
	// memory is refused until the power-up recall ends
	assign decCls = (recalling && isMem) ? nid_pkg::CLS_BAD : rawCls;
	assign decValid = (frState == nid_pkg::FR_OPC) && sckRise && pwrLive
		&& (nextCnt == nid_pkg::OPC_BITS);
	assign addrDone = (frState == nid_pkg::FR_ADDR) && sckRise && pwrLive
		&& (nextCnt == nid_pkg::ADDR_BITS);
	assign swFire = decValid && (curOp == nid_pkg::OP_RST) && armed;

	always_ff @(posedge mclk) begin
		if (rst) begin
			frState <= nid_pkg::FR_IDLE;
			sreg <= '0;
			bitCnt <= '0;
			addrLanes <= nid_pkg::LANES_1;
			opcode <= '0;
			frCls <= nid_pkg::CLS_BAD;
			spiMode3 <= 1'b0;
		end else if (csS) begin
			frState <= nid_pkg::FR_IDLE;
		end else if (!pwrLive) begin
			frState <= nid_pkg::FR_IGNORE;
		end else begin
			case (frState)
				nid_pkg::FR_IDLE: begin
					// select just fell: a new instruction opens
					frState <= nid_pkg::FR_OPC;
					bitCnt <= '0;
					spiMode3 <= sckS;
				end
				nid_pkg::FR_OPC: begin
					if (sckRise) begin
						sreg <= shiftNext;
						bitCnt <= nextCnt;
					end
					if (decValid) begin
						opcode <= curOp;
						frCls <= decCls;
						bitCnt <= '0;
						addrLanes <= nid_pkg::nid_addr_lanes(curOp, proto);
						case (decCls)
							nid_pkg::CLS_BAD, nid_pkg::CLS_RSVD:
								frState <= nid_pkg::FR_IGNORE;
							nid_pkg::CLS_MEMRD, nid_pkg::CLS_MEMWR:
								frState <= nid_pkg::FR_ADDR;
							default: frState <= nid_pkg::FR_DONE;
						endcase
					end
				end
				nid_pkg::FR_ADDR: begin
					if (sckRise) begin
						sreg <= shiftNext;
						bitCnt <= nextCnt;
					end
					if (addrDone)
						frState <= nid_pkg::FR_DONE;
				end
				nid_pkg::FR_DONE, nid_pkg::FR_IGNORE: ;
				default: frState <= nid_pkg::FR_IDLE;
			endcase
		end
	end

	//--------------------------------------------------
	// command hand-off
	//--------------------------------------------------
	logic                       cmdLoad;
	logic                       pendValid;
	nid_pkg::nid_cls_t          pendCls;
	logic [7:0]                 pendOp;
	logic [16:0]                pendAddr;
	logic                       bufInReady;
	logic [nid_pkg::CMD_W-1:0]  bufOut;

	assign cmdLoad = addrDone || (decValid && !isMem && decCls != nid_pkg::CLS_BAD
		&& decCls != nid_pkg::CLS_RSVD);

	// a command arriving while one is pending and the buffer is full is dropped and flagged
	always_ff @(posedge mclk) begin
		if (rst) begin
			pendValid <= 1'b0;
			pendCls <= nid_pkg::CLS_BAD;
			pendOp <= '0;
			pendAddr <= '0;
			cmdOverrun <= 1'b0;
		end else begin
			cmdOverrun <= cmdLoad && pendValid && !bufInReady;
			if (cmdLoad && !(pendValid && !bufInReady)) begin
				pendValid <= 1'b1;
				pendCls <= addrDone ? frCls : decCls;
				pendOp <= addrDone ? opcode : curOp;
				pendAddr <= addrDone ? shiftNext[nid_pkg::ADDR_USED-1:0] : '0;
			end else if (bufInReady) begin
				pendValid <= 1'b0;
			end
		end
	end

	nid_cmd_buf #(
		.WIDTH (nid_pkg::CMD_W),
		.DEPTH (2)
	) u_buf (
		.mclk     (mclk),
		.rst      (rst),
		.inValid  (pendValid),
		.inData   ({pendCls, pendOp, pendAddr}),
		.inReady  (bufInReady),
		.outValid (cmdValid),
		.outReady (cmdReady),
		.outData  (bufOut)
	);

	assign {cmdClass, cmdOpcode, cmdAddr} = bufOut;

	//--------------------------------------------------
	// protocol, write latch, reset, flags
	//--------------------------------------------------
	logic pwrDown;

	assign pwrDown = (pwrState == nid_pkg::PW_OFF);

	always_ff @(posedge mclk) begin
		if (rst || pwrDown || swFire)
			proto <= nid_pkg::PROTO_SINGLE;
		else if (decValid && decCls == nid_pkg::CLS_PROTO)
			case (curOp)
				nid_pkg::OP_TWO_EN: proto <= nid_pkg::PROTO_TWO;
				nid_pkg::OP_FOUR_EN: proto <= nid_pkg::PROTO_FOUR;
				default: proto <= nid_pkg::PROTO_SINGLE;
			endcase
	end

	always_ff @(posedge mclk) begin
		if (rst || pwrDown || swFire)
			writeEnableLatch <= nid_pkg::WEL_RST;
		else if (decValid && decCls == nid_pkg::CLS_WEL)
			writeEnableLatch <= (curOp == nid_pkg::OP_WL_SET);
	end

	// arm lasts exactly one opcode
	always_ff @(posedge mclk) begin
		if (rst) begin
			armed <= 1'b0;
			swResetPulse <= 1'b0;
		end else begin
			swResetPulse <= swFire;
			if (decValid)
				armed <= (curOp == nid_pkg::OP_RST_ARM);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || swFire)
			reservedTaint <= 1'b0;
		else if (decValid && decCls == nid_pkg::CLS_RSVD)
			reservedTaint <= 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			autoSaveEnabled <= nid_pkg::AUTO_SAVE_RST;
		else if (decValid && curOp == nid_pkg::OP_AUTO_ON)
			autoSaveEnabled <= 1'b1;
		else if (decValid && curOp == nid_pkg::OP_AUTO_OFF)
			autoSaveEnabled <= 1'b0;
	end

	// a write in the same cycle as recall end is refused and does not count
	always_ff @(posedge mclk) begin
		if (rst)
			dirty <= 1'b0;
		else if (decValid && decCls == nid_pkg::CLS_MEMWR)
			dirty <= 1'b1;
		else if (recalling && pwrOkS && pwrState == nid_pkg::PW_RECALL && timer == RECALL_LAST)
			dirty <= 1'b0;
	end

	//--------------------------------------------------
	// power sequencing
	//--------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			pwrState <= nid_pkg::PW_RECALL;
			timer <= '0;
			autoSaveReq <= 1'b0;
		end else begin
			autoSaveReq <= 1'b0;
			case (pwrState)
				nid_pkg::PW_RECALL: begin
					timer <= timer + 1'b1;
					if (!pwrOkS)
						pwrState <= nid_pkg::PW_OFF;
					else if (timer == RECALL_LAST)
						pwrState <= nid_pkg::PW_ON;
				end
				nid_pkg::PW_ON: begin
					timer <= '0;
					if (!pwrOkS)
						pwrState <= writeLastBit ? nid_pkg::PW_GRACE : nid_pkg::PW_SAVE;
				end
				nid_pkg::PW_GRACE: begin
					timer <= timer + 1'b1;
					if (timer == GRACE_LAST)
						pwrState <= nid_pkg::PW_SAVE;
				end
				nid_pkg::PW_SAVE: begin
					autoSaveReq <= dirty && autoSaveEnabled;
					pwrState <= nid_pkg::PW_OFF;
				end
				nid_pkg::PW_OFF: begin
					timer <= '0;
					if (pwrOkS)
						pwrState <= nid_pkg::PW_RECALL;
				end
				default: pwrState <= nid_pkg::PW_RECALL;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			statusLockBit <= 1'b0;
			serialIdLockBit <= 1'b0;
			blockProtectBits <= '0;
		end else if (recalling && timer == RECALL_LAST) begin
			statusLockBit <= nvStatusLock;
			serialIdLockBit <= nvIdLock;
			blockProtectBits <= nvBlockProtect;
		end
	end

	// standby is held off while the array is busy
	always_ff @(posedge mclk) begin
		if (rst) begin
			activeMode <= 1'b0;
			standbyMode <= 1'b0;
		end else begin
			activeMode <= !csS;
			standbyMode <= csS && !(arrayBusy || !pwrLive || recalling);
		end
	end

	assign memInhibit = (pwrState != nid_pkg::PW_ON);
	assign hwStoreBusyOut = 1'b0;
	assign hwStoreBusyOeN = !(recalling || arrayBusy || pwrState == nid_pkg::PW_SAVE);
	assign hwStorePullupEn = 1'b1;
	assign wpPullupEn = !quadEnable;
	assign lane3PullupEn = !quadEnable;
	assign ioOut = '0;
	assign ioOeN = '1;
	assign laneProtocol = proto;

	//--------------------------------------------------
	// checks
	//--------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_rst_cmd;
		decValid && curOp == nid_pkg::OP_RST && armed;
	endsequence
	sequence s_rst_effect;
		swResetPulse && proto == nid_pkg::PROTO_SINGLE && !writeEnableLatch;
	endsequence

	property p_recall_busy;
		recalling |-> !hwStoreBusyOeN && memInhibit;
	endproperty
	a_recall_busy: assert property (p_recall_busy) else $error("recall not busy");
	property p_recall_refuse;
		decValid && recalling && isMem |=> frState == nid_pkg::FR_IGNORE;
	endproperty
	a_recall_refuse: assert property (p_recall_refuse) else $error("memory taken in recall");
	property p_wel_set;
		decValid && curOp == nid_pkg::OP_WL_SET && !swFire |=> writeEnableLatch;
	endproperty
	a_wel_set: assert property (p_wel_set) else $error("latch not set");
	property p_wel_clr;
		decValid && curOp == nid_pkg::OP_WL_CLR |=> !writeEnableLatch;
	endproperty
	a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared");
	property p_two_lane;
		decValid && curOp == nid_pkg::OP_TWO_EN && proto != nid_pkg::PROTO_TWO
			|=> proto == nid_pkg::PROTO_TWO;
	endproperty
	a_two_lane: assert property (p_two_lane) else $error("two lane not entered");
	property p_reset_fires;
		s_rst_cmd |=> s_rst_effect;
	endproperty
	a_reset_fires: assert property (p_reset_fires) else $error("reset did not act");
	property p_reset_needs_arm;
		decValid && curOp == nid_pkg::OP_RST && !armed |=> !swResetPulse;
	endproperty
	a_reset_needs_arm: assert property (p_reset_needs_arm) else $error("unarmed reset");
	property p_cfg_four;
		decValid && curOp == nid_pkg::OP_CFG_WR && proto == nid_pkg::PROTO_FOUR
			|-> !cmdLoad ##1 frState == nid_pkg::FR_IGNORE;
	endproperty
	a_cfg_four: assert property (p_cfg_four) else $error("config write in four lane");
	property p_invalid;
		decValid && decCls == nid_pkg::CLS_BAD |=> frState == nid_pkg::FR_IGNORE;
	endproperty
	a_invalid: assert property (p_invalid) else $error("invalid opcode not ignored");
	property p_addr;
		addrDone && !pendValid |=> pendValid && pendAddr == $past(shiftNext[16:0]);
	endproperty
	a_addr: assert property (p_addr) else $error("address low bits lost");
	property p_pd_quiet;
		!pwrLive |-> !decValid && !addrDone;
	endproperty
	a_pd_quiet: assert property (p_pd_quiet) else $error("decode during power loss");
endmodule : nid_decoder
`default_nettype wire

// file: tb/nid_host.sv
`timescale 1ns/10ps
`default_nettype none
module nid_host (
	output logic       csN,
	output logic       sck,
	output logic [3:0] ioIn
);
	// ------
	// host, mode 0 or 3 at 12.5 MHz, so plain reads stay in range
	// ------
	logic sckIdle;
	initial begin
		csN = 1'b1;
		sck = 1'b0;
		ioIn = 4'h0;
		sckIdle = 1'b0;
	end
	task automatic frame(input logic [7:0] op, input int w);
		logic [31:0] bits;
		int          i;
		bits = {op, 24'hff1234};
		sck = sckIdle;
		#8 csN = 1'b0;
		for (i = 32 - w; i >= 0; i -= w) begin
			#40 ioIn = 4'((bits >> i) & ((32'h1 << w) - 1));
			sck = 1'b0;
			#40 sck = 1'b1;
		end
		#40 sck = sckIdle;
		// released lanes must not keep the last bit
		ioIn = ~ioIn;
		#40 csN = 1'b1;
		#40;
	endtask : frame
endmodule : nid_host
`default_nettype wire

// file: tb/serial_nvram_instruction_decoder_test.sv
`timescale 1ns/10ps
`default_nettype none
module serial_nvram_instruction_decoder_test;
	// ------
	// power-up state, decode table, then reset pair, buffer and power
	// ------
	localparam logic [3:0] BAD = 4'(nid_pkg::CLS_BAD), WRITE_ENABLE_LATCH = 4'(nid_pkg::CLS_WEL);
	localparam logic [3:0] PRO = 4'(nid_pkg::CLS_PROTO), MRD = 4'(nid_pkg::CLS_MEMRD);
	localparam logic [3:0] MWR = 4'(nid_pkg::CLS_MEMWR), RTC = 4'(nid_pkg::CLS_RTC);
	localparam logic [3:0] PWR = 4'(nid_pkg::CLS_PWR), REG = 4'(nid_pkg::CLS_REG);
	localparam logic [3:0] SN = 4'(nid_pkg::CLS_SN), NV = 4'(nid_pkg::CLS_NV);
	logic mclk = 1'b0, rst = 1'b1, pwrOk = 1'b1, quadEnable = 1'b0, cmdReady = 1'b0;
	logic csN, sck, cmdValid, cmdOverrun, autoSaveReq, sawOvr = 1'b0, sawSave = 1'b0;
	logic arrayBusy = 1'b0, writeLastBit = 1'b0, hwStorePullupEn, statusLockBit;
	logic spiMode3, standbyMode;
	logic hwStoreBusyOeN, wpPullupEn, lane3PullupEn, writeEnableLatch, memInhibit, reservedTaint;
	logic [3:0]  ioIn, ioOeN, cmdClass;
	logic [7:0]  cmdOpcode;
	logic [16:0] cmdAddr;
	logic [2:0]  blockProtectBits;
	nid_pkg::nid_proto_t laneProtocol;
	int n_fail = 0, tests_run = 0, cyc = 0, i, k;
	logic [15:0] rows [27] = '{{8'h06, 4'h1, WRITE_ENABLE_LATCH}, {8'h04, 4'h1, WRITE_ENABLE_LATCH}, {8'h03, 4'h1, MRD},
		{8'h0b, 4'h1, MRD}, {8'h02, 4'h1, MWR}, {8'h3b, 4'h1, MRD}, {8'h6b, 4'h1, MRD},
		{8'ha2, 4'h1, MWR}, {8'h32, 4'h1, MWR}, {8'hff, 4'h1, BAD}, {8'h56, 4'h1, RTC},
		{8'h55, 4'h1, RTC}, {8'hba, 4'h1, PWR}, {8'h05, 4'h1, REG}, {8'h87, 4'h1, REG},
		{8'hc3, 4'h1, SN}, {8'h8f, 4'h1, NV}, {8'h8e, 4'h1, NV}, {8'h37, 4'h1, PRO},
		{8'h3b, 4'h2, BAD}, {8'h05, 4'h2, REG}, {8'h38, 4'h2, PRO}, {8'h87, 4'h4, BAD},
		{8'h6b, 4'h4, BAD}, {8'h04, 4'h4, WRITE_ENABLE_LATCH}, {8'h37, 4'h4, PRO}, {8'hff, 4'h2, PRO}};
	nid_decoder #(.RECALL_NS(80), .GRACE_NS(40)) uut (.mclk, .rst, .csN, .sck, .ioIn, .ioOut(),
		.ioOeN, .pwrOk, .quadEnable, .arrayBusy, .writeLastBit, .nvStatusLock(1'b1),
		.nvIdLock(1'b0), .nvBlockProtect(3'h5), .hwStoreBusyOut(), .hwStoreBusyOeN,
		.hwStorePullupEn, .wpPullupEn, .lane3PullupEn, .writeEnableLatch, .statusLockBit,
		.serialIdLockBit(), .blockProtectBits, .laneProtocol, .spiMode3, .activeMode(),
		.standbyMode, .memInhibit, .autoSaveReq, .autoSaveEnabled(), .swResetPulse(),
		.reservedTaint, .cmdValid, .cmdReady, .cmdClass, .cmdOpcode, .cmdAddr, .cmdOverrun);
	nid_host h (.csN, .sck, .ioIn);
	initial forever #4 mclk = ~mclk;
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop
	always @(posedge mclk) begin
		cyc++;
		if (cmdOverrun === 1'b1) sawOvr = 1'b1;
		if (autoSaveReq === 1'b1) sawSave = 1'b1;
		if (cyc == 30000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic pop;
		@(posedge mclk) cmdReady <= 1'b1;
		@(posedge mclk) cmdReady <= 1'b0;
		@(negedge mclk);
	endtask : pop
	task automatic sp(input logic [7:0] op);
		h.frame(op, 1);
		@(negedge mclk);
		if (cmdValid === 1'b1) pop();
	endtask : sp
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk("busyOeN", 0, hwStoreBusyOeN);
		chk("inhibit", 1, memInhibit);
		chk("proto", 0, laneProtocol);
		chk("ioOeN", 17'hf, ioOeN);
		chk("wel", 0, writeEnableLatch);
		repeat (20) @(negedge mclk);
		chk("bp", 17'h5, blockProtectBits);
		chk("srLock", 1, statusLockBit);
		chk("hsbPu", 1, hwStorePullupEn);
		chk("standby", 1, standbyMode);
		chk("lane3Pu", 1, lane3PullupEn);
		@(posedge mclk);
		quadEnable <= 1'b1;
		arrayBusy <= 1'b1;
		repeat (2) @(negedge mclk);
		chk("wpPu", 0, wpPullupEn);
		chk("standby", 0, standbyMode);
		chk("busyOeN", 0, hwStoreBusyOeN);
		@(posedge mclk);
		quadEnable <= 1'b0;
		arrayBusy <= 1'b0;
		@(negedge mclk);
		$display("reset test done");
		for (i = 0; i < 27; i++) begin
			h.frame(rows[i][15:8], int'(rows[i][7:4]));
			@(negedge mclk);
			k = int'(rows[i][3:0] != BAD);
			chk("valid", 17'(k), cmdValid);
			if (k != 0) begin
				chk("class", rows[i][3:0], cmdClass);
				chk("opcode", rows[i][15:8], cmdOpcode);
				if (rows[i][3:0] == MRD || rows[i][3:0] == MWR)
					chk("addr", 17'h11234, cmdAddr);
				pop();
			end
		end
		$display("decode table done");
		sp(8'hc5);
		chk("taint", 1, reservedTaint);
		sp(8'h66);
		sp(8'h05);
		sp(8'h99);
		chk("taint", 1, reservedTaint);
		sp(8'h66);
		sp(8'h99);
		chk("taint", 0, reservedTaint);
		$display("software reset test done");
		h.sckIdle = 1'b1;
		h.frame(8'h06, 1);
		chk("wel", 1, writeEnableLatch);
		chk("mode3", 1, spiMode3);
		h.sckIdle = 1'b0;
		h.frame(8'h04, 1);
		chk("wel", 0, writeEnableLatch);
		chk("mode3", 0, spiMode3);
		h.frame(8'h05, 1);
		h.frame(8'h01, 1);
		chk("overrun", 1, sawOvr);
		chk("opcode", 17'h06, cmdOpcode);
		k = 0;
		while (cmdValid === 1'b1 && k < 8) begin
			pop();
			k++;
		end
		chk("drained", 17'h3, 17'(k));
		$display("buffer test done");
		sp(8'h06);
		@(posedge mclk);
		pwrOk <= 1'b0;
		writeLastBit <= 1'b1;
		repeat (7) @(negedge mclk);
		chk("grace", 0, sawSave);
		repeat (13) @(negedge mclk);
		chk("save", 1, sawSave);
		chk("inhibit", 1, memInhibit);
		h.frame(8'h05, 1);
		chk("valid", 0, cmdValid);
		@(posedge mclk);
		pwrOk <= 1'b1;
		writeLastBit <= 1'b0;
		repeat (4) @(negedge mclk);
		chk("busyOeN", 0, hwStoreBusyOeN);
		repeat (20) @(negedge mclk);
		chk("inhibit", 0, memInhibit);
		chk("wel", 0, writeEnableLatch);
		$display("power test done");
		report_and_stop();
	end
endmodule : serial_nvram_instruction_decoder_test
`default_nettype wire
